// File: xfbc_consts.vh
// How it works
// [R1] Min on-time code: 45, 65, 25, 45 ns
// [R2] Pin function 0: sync input, register mode
// [R3] Mode code 00 PFM, 11 PWM, others reserved
// [R4] Pin function 1: pin low PWM, high PFM
// [R5] Software avoids mode writes in pin mode
// [R6] PFM on-time code: 120, 210, 300, 550 ns
// [R7] Integrator should program PFM code 0b10
// [R8] Soft-start duration from one programmed bit
// [R9] Current limit: one of four thresholds
// [R10] Slope compensation from 6-bit code table
// [R11] Overvoltage and undervoltage reported separately
// [R12] Overvoltage drives each power-good when enabled
// [R13] Undervoltage drives each power-good when enabled
// [R14] Sticky fault flags stay set after fault
// [R15] Writing one clears a sticky flag
// [R16] Live fault bits read-only, not latched
// [R17] Programmed values loaded once after reset
// [R18] Mode changes at switching-cycle boundary; code also changes it at once while regulator_run_q is low
//
// Purpose: constants of the external-FET buck mode and fault logic
// Assumes: 50 MHz clock, 20 ns period
// Notes:   definitions only
`ifndef XFBC_CONSTS_VH
`define XFBC_CONSTS_VH

`define XFBC_AW          4
`define XFBC_DW          16
`define XFBC_A_MODE      4'h0
`define XFBC_A_FAULT     4'h1
`define XFBC_A_IRQ_STAT  4'h2
`define XFBC_A_IRQ_MASK  4'h3
`define XFBC_A_CFG       4'h4
`define XFBC_A_SLOPE     4'h5

`define XFBC_B_UV        0
`define XFBC_B_OV        1
`define XFBC_LIVE_SH     2
`define XFBC_NFLT        2

`define XFBC_MODE_PFM    2'h0
`define XFBC_MODE_PWM    2'h3
`define XFBC_MODE_RST    2'h3

`define XFBC_CLK_NS      10'h014
`define XFBC_TON_00_NS   10'h02D
`define XFBC_TON_01_NS   10'h041
`define XFBC_TON_10_NS   10'h019
`define XFBC_TON_11_NS   10'h02D
`define XFBC_PFM_00_NS   10'h078
`define XFBC_PFM_01_NS   10'h0D2
`define XFBC_PFM_10_NS   10'h12C
`define XFBC_PFM_11_NS   10'h226

`define XFBC_CFG_TON_SH  0
`define XFBC_CFG_PFM_SH  2
`define XFBC_CFG_SS_B    4
`define XFBC_CFG_ILIM_SH 5
`define XFBC_CFG_PIN_B   7
`define XFBC_CFG_MODE_B  8
`define XFBC_CFG_RDY_B   9

`endif

// File: xfbc_slope_rom.v
// Purpose: slope compensation lookup, mV/us per code
// Assumes: same clock as the controller
// Notes:   read data registered, one cycle latency
`timescale 1ns/1ps
`include "xfbc_consts.vh"
module xfbc_slope_rom (
  input  wire        clk,
  input  wire        rstn,
  input  wire        clk_en,
  input  wire [5:0]  addr,
  output reg  [10:0] data_q
);
  reg [10:0] data_d;

  always @* begin
    case (addr)
      6'h00: data_d = 11'h000; 6'h01: data_d = 11'h00A;
      6'h02: data_d = 11'h014; 6'h03: data_d = 11'h01F;
      6'h04: data_d = 11'h029; 6'h05: data_d = 11'h033;
      6'h06: data_d = 11'h03E; 6'h07: data_d = 11'h048;
      6'h08: data_d = 11'h052; 6'h09: data_d = 11'h05C;
      6'h0A: data_d = 11'h067; 6'h0B: data_d = 11'h071;
      6'h0C: data_d = 11'h07B; 6'h0D: data_d = 11'h086;
      6'h0E: data_d = 11'h090; 6'h0F: data_d = 11'h09A;
      6'h10: data_d = 11'h0AF; 6'h11: data_d = 11'h0C3;
      6'h12: data_d = 11'h0D8; 6'h13: data_d = 11'h0ED;
      6'h14: data_d = 11'h102; 6'h15: data_d = 11'h117;
      6'h16: data_d = 11'h12B; 6'h17: data_d = 11'h140;
      6'h18: data_d = 11'h154; 6'h19: data_d = 11'h169;
      6'h1A: data_d = 11'h17D; 6'h1B: data_d = 11'h192;
      6'h1C: data_d = 11'h1A7; 6'h1D: data_d = 11'h1BC;
      6'h1E: data_d = 11'h1D0; 6'h1F: data_d = 11'h1E5;
      6'h20: data_d = 11'h1F8; 6'h21: data_d = 11'h20D;
      6'h22: data_d = 11'h222; 6'h23: data_d = 11'h236;
      6'h24: data_d = 11'h24B; 6'h25: data_d = 11'h260;
      6'h26: data_d = 11'h274; 6'h27: data_d = 11'h289;
      6'h28: data_d = 11'h29D; 6'h29: data_d = 11'h2B2;
      6'h2A: data_d = 11'h2C6; 6'h2B: data_d = 11'h2DB;
      6'h2C: data_d = 11'h2F0; 6'h2D: data_d = 11'h304;
      6'h2E: data_d = 11'h319; 6'h2F: data_d = 11'h32E;
      6'h30: data_d = 11'h342; 6'h31: data_d = 11'h357;
      6'h32: data_d = 11'h36C; 6'h33: data_d = 11'h395;
      6'h34: data_d = 11'h3AA; 6'h35: data_d = 11'h3BE;
      6'h36: data_d = 11'h3D3; 6'h37: data_d = 11'h3E7;
      6'h38: data_d = 11'h3FC; 6'h39: data_d = 11'h411;
      6'h3A: data_d = 11'h425; 6'h3B: data_d = 11'h43A;
      6'h3C: data_d = 11'h44F; 6'h3D: data_d = 11'h464;
      6'h3E: data_d = 11'h464; 6'h3F: data_d = 11'h478;
      default: data_d = 11'h000;
    endcase
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      data_q <= 11'h000;
    end else if (clk_en) begin
      data_q <= data_d;
    end
  end
endmodule // xfbc_slope_rom

// File: xfbc_ctrl.v
// Purpose: mode select, configuration hold and fault report of the
//          external-FET buck controller
// Assumes: programmed inputs are static and on the clk domain;
//          pin, comparator and cycle inputs are asynchronous
// Notes:   register port answers reads one cycle later
`timescale 1ns/1ps
`include "xfbc_consts.vh"
module xfbc_ctrl (
  input  wire                 clk,
  input  wire                 rstn,
  input  wire                 clk_en,
  input  wire [`XFBC_AW-1:0]  addr,
  input  wire [`XFBC_DW-1:0]  wdata,
  input  wire                 wr,
  input  wire                 rd,
  output reg  [`XFBC_DW-1:0]  rdata_q,
  input  wire [1:0]           prog_min_on_time,
  input  wire                 prog_shared_pin_function,
  input  wire [1:0]           prog_default_operating_mode,
  input  wire [1:0]           prog_pfm_on_time,
  input  wire                 prog_soft_start_time,
  input  wire [1:0]           prog_current_limit,
  input  wire [5:0]           prog_slope_compensation,
  input  wire                 prog_ov_to_good_out_a,
  input  wire                 prog_ov_to_good_out_b,
  input  wire                 prog_uv_to_good_out_a,
  input  wire                 prog_uv_to_good_out_b,
  input  wire                 regulator_enable,
  input  wire                 shared_mode_sync_pin,
  input  wire                 switch_cycle_start,
  input  wire                 feedback_uv_cmp,
  input  wire                 feedback_ov_cmp,
  output reg                  cfg_ready_q,
  output reg                  regulator_run_q,
  output reg                  pfm_mode_q,
  output reg                  sync_clock_q,
  output reg  [9:0]           min_on_time_ns_q,
  output reg  [5:0]           min_on_cycles_q,
  output reg  [9:0]           pfm_on_time_ns_q,
  output reg  [5:0]           pfm_on_cycles_q,
  output reg                  soft_start_sel_q,
  output reg  [1:0]           current_limit_sel_q,
  output reg  [10:0]          slope_mv_per_us_q,
  output reg                  power_good_out_a_q,
  output reg                  power_good_out_b_q,
  output reg                  irq_q
);

  // Least times round up to whole clock cycles
  function [5:0] ns_to_cyc;
    input [9:0] ns;
    reg   [9:0] sum;
    reg   [9:0] quo;
    begin
      sum       = ns + `XFBC_CLK_NS - 10'h001;
      quo       = sum / `XFBC_CLK_NS;
      ns_to_cyc = quo[5:0];
    end
  endfunction

  function hit;
    input [`XFBC_AW-1:0] a;
    input [`XFBC_AW-1:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  function [9:0] ton_ns;
    input [1:0] code;
    begin
      case (code)
        2'h0:    ton_ns = `XFBC_TON_00_NS;
        2'h1:    ton_ns = `XFBC_TON_01_NS;
        2'h2:    ton_ns = `XFBC_TON_10_NS;
        default: ton_ns = `XFBC_TON_11_NS;
      endcase
    end
  endfunction

  function [9:0] pfm_ns;
    input [1:0] code;
    begin
      case (code)
        2'h0:    pfm_ns = `XFBC_PFM_00_NS;
        2'h1:    pfm_ns = `XFBC_PFM_01_NS;
        2'h2:    pfm_ns = `XFBC_PFM_10_NS;
        default: pfm_ns = `XFBC_PFM_11_NS;
      endcase
    end
  endfunction

  // Synchronisers: bit 0 uv, 1 ov, 2 pin, 3 cycle start
  wire [3:0] async_in;
  reg  [3:0] meta_q;
  reg  [3:0] sync_q;
  reg  [3:0] hist_q;

  assign async_in = {switch_cycle_start, shared_mode_sync_pin,
                     feedback_ov_cmp, feedback_uv_cmp};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
      always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          meta_q[gi] <= 1'b0;
          sync_q[gi] <= 1'b0;
          hist_q[gi] <= 1'b0;
        end else if (clk_en) begin
          meta_q[gi] <= async_in[gi];
          sync_q[gi] <= meta_q[gi];
          hist_q[gi] <= sync_q[gi];
        end
      end
    end
  endgenerate

  wire                  pin_lvl;
  wire                  cyc_rise;
  wire [`XFBC_NFLT-1:0] live;
  wire [`XFBC_NFLT-1:0] rise;

  assign pin_lvl  = sync_q[2];
  assign cyc_rise = sync_q[3] & ~hist_q[3];
  assign live     = sync_q[1:0]; // [R11]
  assign rise     = sync_q[1:0] & ~hist_q[1:0];

  wire wr_mode;
  wire wr_fault;
  wire wr_mask;
  wire rd_irq;

  assign wr_mode  = wr & hit(addr, `XFBC_A_MODE);
  assign wr_fault = wr & hit(addr, `XFBC_A_FAULT);
  assign wr_mask  = wr & hit(addr, `XFBC_A_IRQ_MASK);
  assign rd_irq   = rd & hit(addr, `XFBC_A_IRQ_STAT);

  // Working copies of the programmed settings, plus the mode and interrupt mask registers
  reg       pin_func_q;
  reg [1:0] ton_code_q;
  reg [1:0] pfm_code_q;
  reg [5:0] slope_code_q;
  reg       ov_a_q;
  reg       ov_b_q;
  reg       uv_a_q;
  reg       uv_b_q;
  reg [1:0] reg_operating_mode_q;
  reg [1:0] irq_mask_q;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_ready_q         <= 1'b0;
      pin_func_q          <= 1'b0;
      ton_code_q          <= 2'h0;
      pfm_code_q          <= 2'h0;
      slope_code_q        <= 6'h00;
      soft_start_sel_q    <= 1'b0;
      current_limit_sel_q <= 2'h0;
      ov_a_q              <= 1'b0;
      ov_b_q              <= 1'b0;
      uv_a_q              <= 1'b0;
      uv_b_q              <= 1'b0;
    end else if (clk_en && !cfg_ready_q) begin
      cfg_ready_q         <= 1'b1;                        // [R17]
      pin_func_q          <= prog_shared_pin_function;    // [R17]
      ton_code_q          <= prog_min_on_time;            // [R1]
      pfm_code_q          <= prog_pfm_on_time;            // [R6]
      slope_code_q        <= prog_slope_compensation;     // [R10]
      soft_start_sel_q    <= prog_soft_start_time;        // [R8]
      current_limit_sel_q <= prog_current_limit;          // [R9]
      ov_a_q              <= prog_ov_to_good_out_a;
      ov_b_q              <= prog_ov_to_good_out_b;
      uv_a_q              <= prog_uv_to_good_out_a;
      uv_b_q              <= prog_uv_to_good_out_b;
    end
  end

  // Derived timing outputs, stable once loaded, and the run flag, which follows regulator_enable
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      min_on_time_ns_q <= 10'h000;
      min_on_cycles_q  <= 6'h00;
      pfm_on_time_ns_q <= 10'h000;
      pfm_on_cycles_q  <= 6'h00;
      regulator_run_q  <= 1'b0;
    end else if (clk_en) begin
      min_on_time_ns_q <= ton_ns(ton_code_q);             // [R1]
      min_on_cycles_q  <= ns_to_cyc(ton_ns(ton_code_q));  // [R1]
      pfm_on_time_ns_q <= pfm_ns(pfm_code_q);             // [R6]
      pfm_on_cycles_q  <= ns_to_cyc(pfm_ns(pfm_code_q));  // [R6]
      regulator_run_q  <= cfg_ready_q & regulator_enable; // [R17] [R8]
    end
  end

  wire [10:0] slope_rom;

  xfbc_slope_rom u_slope (
    .clk    (clk),
    .rstn   (rstn),
    .clk_en (clk_en),
    .addr   (slope_code_q),
    .data_q (slope_rom)
  );

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      slope_mv_per_us_q <= 11'h000;
    end else if (clk_en) begin
      slope_mv_per_us_q <= slope_rom; // [R10]
    end
  end

  // Mode register: defaults to the programmed mode at load
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_operating_mode_q <= `XFBC_MODE_RST;
    end else if (clk_en) begin
      if (!cfg_ready_q) begin
        reg_operating_mode_q <= prog_default_operating_mode; // [R2]
      end else if (wr_mode) begin
        // Stored even in pin mode, where the pin wins
        reg_operating_mode_q <= wdata[1:0]; // [R5]
      end
    end
  end

  // Requested mode; reserved codes keep the present mode
  reg want_pfm;

  always @* begin
    want_pfm = pfm_mode_q;
    if (pin_func_q) begin
      want_pfm = pin_lvl; // [R4]
    end else begin
      case (reg_operating_mode_q)
        `XFBC_MODE_PFM: want_pfm = 1'b1; // [R3]
        `XFBC_MODE_PWM: want_pfm = 1'b0; // [R3]
        default:        want_pfm = pfm_mode_q;
      endcase
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pfm_mode_q   <= 1'b0;
      sync_clock_q <= 1'b0;
    end else if (clk_en) begin
      if (cfg_ready_q && (cyc_rise || !regulator_run_q)) begin
        pfm_mode_q <= want_pfm; // [R18] [R2]
      end
      sync_clock_q <= ~pin_func_q & pin_lvl; // [R2]
    end
  end

  // Sticky faults and interrupt status, one lane per fault
  reg [`XFBC_NFLT-1:0] sticky_q;
  reg [`XFBC_NFLT-1:0] irq_stat_q;

  generate
    for (gi = 0; gi < `XFBC_NFLT; gi = gi + 1) begin : g_flt
      always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          sticky_q[gi]   <= 1'b0;
          irq_stat_q[gi] <= 1'b0;
        end else if (clk_en) begin
          if (live[gi]) begin
            sticky_q[gi] <= 1'b1; // [R14]
          end else if (wr_fault && wdata[gi]) begin
            sticky_q[gi] <= 1'b0; // [R15]
          end
          if (rise[gi]) begin
            irq_stat_q[gi] <= 1'b1;
          end else if (rd_irq) begin
            irq_stat_q[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_mask_q <= 2'h0;
      irq_q      <= 1'b0;
    end else if (clk_en) begin
      if (wr_mask) begin
        irq_mask_q <= wdata[1:0];
      end
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  // Power-good outputs, high while an enabled fault is present
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      power_good_out_a_q <= 1'b0;
      power_good_out_b_q <= 1'b0;
    end else if (clk_en) begin
      power_good_out_a_q <= (ov_a_q & live[`XFBC_B_OV])    // [R12]
                          | (uv_a_q & live[`XFBC_B_UV]);   // [R13]
      power_good_out_b_q <= (ov_b_q & live[`XFBC_B_OV])    // [R12]
                          | (uv_b_q & live[`XFBC_B_UV]);   // [R13]
    end
  end

  // Read mux; unmapped addresses read zero
  reg [`XFBC_DW-1:0] rmux;

  always @* begin
    rmux = {`XFBC_DW{1'b0}};
    case (addr)
      `XFBC_A_MODE: begin
        rmux[1:0] = reg_operating_mode_q;
      end
      `XFBC_A_FAULT: begin
        rmux[`XFBC_NFLT-1:0] = sticky_q;
        rmux[`XFBC_LIVE_SH +: `XFBC_NFLT] = live; // [R16]
      end
      `XFBC_A_IRQ_STAT: begin
        rmux[`XFBC_NFLT-1:0] = irq_stat_q;
      end
      `XFBC_A_IRQ_MASK: begin
        rmux[1:0] = irq_mask_q;
      end
      `XFBC_A_CFG: begin
        rmux[`XFBC_CFG_TON_SH +: 2]  = ton_code_q;
        rmux[`XFBC_CFG_PFM_SH +: 2]  = pfm_code_q;
        rmux[`XFBC_CFG_SS_B]         = soft_start_sel_q;
        rmux[`XFBC_CFG_ILIM_SH +: 2] = current_limit_sel_q;
        rmux[`XFBC_CFG_PIN_B]        = pin_func_q;
        rmux[`XFBC_CFG_MODE_B]       = pfm_mode_q;
        rmux[`XFBC_CFG_RDY_B]        = cfg_ready_q;
      end
      `XFBC_A_SLOPE: begin
        rmux[10:0] = slope_mv_per_us_q;
      end
      default: begin
        rmux = {`XFBC_DW{1'b0}};
      end
    endcase
  end

  // Data stand only in the cycle after the read strobe
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= {`XFBC_DW{1'b0}};
    end else if (clk_en) begin
      rdata_q <= rd ? rmux : {`XFBC_DW{1'b0}};
    end
  end

endmodule // xfbc_ctrl

// File: xfbc_stage_model.sv
// Purpose: power stage and feedback comparators beside the controller
// Assumes: cycle boundaries only come while the regulator runs
// Notes:   comparator levels follow the fault commands of the bench
`timescale 1ns/1ps
module xfbc_stage_model (
  input  wire clk,
  input  wire run,
  input  wire slow,
  input  wire uv_cmd,
  input  wire ov_cmd,
  output reg  cycle_start,
  output wire uv_cmp,
  output wire ov_cmp
);
  reg [5:0] cnt_q;
  initial begin
    cycle_start = 1'b0;
    cnt_q = 6'h00;
  end
  // Boundaries stand still while the regulator is stopped
  always @(posedge clk) begin
    cnt_q <= (!run || cnt_q == (slow ? 6'h27 : 6'h07)) ? 6'h00 : cnt_q + 6'h01;
    cycle_start <= run && cnt_q < 6'h02;
  end
  assign uv_cmp = uv_cmd;
  assign ov_cmp = ov_cmd;
endmodule // xfbc_stage_model

// File: xfbc_ctrl_monitor.sv
// Purpose: port assertions of the buck mode and fault logic
// Assumes: programmed inputs change only while rstn is low
// Notes:   bound to every xfbc_ctrl
`timescale 1ns/1ps
module xfbc_ctrl_monitor (
  input wire        clk,
  input wire        rstn,
  input wire [1:0]  prog_min_on_time,
  input wire        prog_shared_pin_function,
  input wire [1:0]  prog_pfm_on_time,
  input wire        prog_soft_start_time,
  input wire [1:0]  prog_current_limit,
  input wire [5:0]  prog_slope_compensation,
  input wire        prog_ov_to_good_out_a,
  input wire        prog_ov_to_good_out_b,
  input wire        prog_uv_to_good_out_a,
  input wire        prog_uv_to_good_out_b,
  input wire        shared_mode_sync_pin,
  input wire        switch_cycle_start,
  input wire        feedback_uv_cmp,
  input wire        feedback_ov_cmp,
  input wire        cfg_ready_q,
  input wire        regulator_run_q,
  input wire        pfm_mode_q,
  input wire        sync_clock_q,
  input wire [9:0]  min_on_time_ns_q,
  input wire [9:0]  pfm_on_time_ns_q,
  input wire        soft_start_sel_q,
  input wire [1:0]  current_limit_sel_q,
  input wire [10:0] slope_mv_per_us_q,
  input wire        power_good_out_a_q,
  input wire        power_good_out_b_q
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  function [9:0] min_ns(input [1:0] c);
    min_ns = c == 2'h1 ? 10'h041 : c == 2'h2 ? 10'h019 : 10'h02D;
  endfunction
  function [9:0] pfm_ns(input [1:0] c);
    pfm_ns = c == 2'h0 ? 10'h078 : c == 2'h1 ? 10'h0D2 : c == 2'h2 ? 10'h12C : 10'h226;
  endfunction
  AST_MIN_ON: assert property ($past(cfg_ready_q, 2) |->
    min_on_time_ns_q == min_ns(prog_min_on_time)) else $error("min on-time wrong");
  AST_PFM_ON: assert property ($past(cfg_ready_q, 2) |->
    pfm_on_time_ns_q == pfm_ns(prog_pfm_on_time)) else $error("pfm on-time wrong");
  AST_SLOPE_ENDS: assert property ($past(cfg_ready_q, 3) &&
    (&prog_slope_compensation || prog_slope_compensation == 6'h00) |->
    slope_mv_per_us_q == (&prog_slope_compensation ? 11'h478 : 11'h000))
    else $error("slope end value wrong");
  AST_CFG_HOLD: assert property ($past(cfg_ready_q, 2) |-> cfg_ready_q &&
    soft_start_sel_q == prog_soft_start_time && current_limit_sel_q == prog_current_limit)
    else $error("held configuration wrong");
  AST_PG_A: assert property ($past(cfg_ready_q, 4) |-> power_good_out_a_q ==
    ($past(feedback_ov_cmp, 3) && prog_ov_to_good_out_a ||
     $past(feedback_uv_cmp, 3) && prog_uv_to_good_out_a)) else $error("power good a wrong");
  AST_PG_B: assert property ($past(cfg_ready_q, 4) |-> power_good_out_b_q ==
    ($past(feedback_ov_cmp, 3) && prog_ov_to_good_out_b ||
     $past(feedback_uv_cmp, 3) && prog_uv_to_good_out_b)) else $error("power good b wrong");
  AST_SYNC_OFF: assert property (cfg_ready_q && prog_shared_pin_function |->
    !sync_clock_q) else $error("sync clock active in pin mode");
  AST_PIN_MODE: assert property ($past(cfg_ready_q, 4) && prog_shared_pin_function &&
    !$past(regulator_run_q) |-> pfm_mode_q == $past(shared_mode_sync_pin, 3))
    else $error("pin mode polarity wrong");
  AST_MODE_EDGE: assert property ($changed(pfm_mode_q) && $past(regulator_run_q) |->
    $past(switch_cycle_start, 3) && !$past(switch_cycle_start, 4))
    else $error("mode changed off a cycle boundary");
  cover property (power_good_out_a_q);
  cover property (power_good_out_b_q);
  cover property ($rose(pfm_mode_q) && regulator_run_q);
endmodule // xfbc_ctrl_monitor
bind xfbc_ctrl xfbc_ctrl_monitor u_mon (.*);

// File: test_xfbc_ctrl.sv
// Purpose: self-checking bench of the buck mode and fault logic
// Assumes: reads answer one cycle after the strobe
// Notes:   rows cover the programmed decodes, faults follow by hand
`timescale 1ns/1ps
module test_xfbc_ctrl;
  reg         clk = 1'b0, rstn = 1'b0, clk_en = 1'b1, wr = 1'b0, rd = 1'b0;
  reg  [3:0]  addr = 4'h0;
  reg  [15:0] wdata = 16'h0000;
  reg  [1:0]  prog_min_on_time = 2'h0, prog_pfm_on_time = 2'h0, prog_current_limit = 2'h0;
  reg  [1:0]  prog_default_operating_mode = 2'h3;
  reg         prog_shared_pin_function = 1'b0, prog_soft_start_time = 1'b0;
  reg  [5:0]  prog_slope_compensation = 6'h00;
  reg         prog_ov_to_good_out_a = 1'b1, prog_ov_to_good_out_b = 1'b0;
  reg         prog_uv_to_good_out_a = 1'b0, prog_uv_to_good_out_b = 1'b1;
  reg         regulator_enable = 1'b0, shared_mode_sync_pin = 1'b0;
  reg         slow = 1'b1, uv_cmd = 1'b0, ov_cmd = 1'b0;
  wire        switch_cycle_start, feedback_uv_cmp, feedback_ov_cmp;
  wire [15:0] rdata_q;
  wire        cfg_ready_q, regulator_run_q, pfm_mode_q, sync_clock_q, irq_q;
  wire [9:0]  min_on_time_ns_q, pfm_on_time_ns_q;
  wire [5:0]  min_on_cycles_q, pfm_on_cycles_q;
  wire        soft_start_sel_q, power_good_out_a_q, power_good_out_b_q;
  wire [1:0]  current_limit_sel_q;
  wire [10:0] slope_mv_per_us_q;
  integer     mismatches = 0, checked = 0, cycles = 0, i;
  reg  [9:0]  min_ns [0:3] = '{10'h02D, 10'h041, 10'h019, 10'h02D};
  reg  [5:0]  min_cy [0:3] = '{6'h03, 6'h04, 6'h02, 6'h03};
  reg  [9:0]  pfm_ns [0:3] = '{10'h078, 10'h0D2, 10'h12C, 10'h226};
  reg  [5:0]  pfm_cy [0:3] = '{6'h06, 6'h0B, 6'h0F, 6'h1C};
  reg  [5:0]  sl_code [0:3] = '{6'h00, 6'h32, 6'h3E, 6'h3F};
  reg  [10:0] sl_val [0:3] = '{11'h000, 11'h36C, 11'h464, 11'h478};

  xfbc_ctrl u_dut (.*);
  xfbc_stage_model u_stage (.clk(clk), .run(regulator_run_q), .slow(slow), .uv_cmd(uv_cmd),
    .ov_cmd(ov_cmd), .cycle_start(switch_cycle_start), .uv_cmp(feedback_uv_cmp),
    .ov_cmp(feedback_ov_cmp));

  initial begin
    forever #10 clk = ~clk;
  end

  task wrap_up;
    begin
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
        $display("verification passed");
      end else begin
        $display("verification failed");
      end
      $finish;
    end
  endtask

  task cmp(input string n, input [15:0] e, input [15:0] s);
    begin
      checked = checked + 1;
      if (s !== e) begin
        mismatches = mismatches + 1;
        $display("mismatch %s expected %h seen %h", n, e, s);
      end
    end
  endtask

  task wr_reg(input [3:0] a, input [15:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask

  task rd_chk(input [3:0] a, input [15:0] e);
    begin
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      cmp("rdata", e, rdata_q);
    end
  endtask

  // Programmed values only change while reset is held
  task row(input integer r);
    begin
      @(posedge clk);
      rstn <= 1'b0;
      prog_min_on_time <= r[1:0];
      prog_pfm_on_time <= ~r[1:0];
      prog_soft_start_time <= r[0];
      prog_current_limit <= r[1:0];
      prog_slope_compensation <= sl_code[r];
      prog_shared_pin_function <= r[1];
      prog_default_operating_mode <= (r == 0) ? 2'h0 : 2'h3;
      shared_mode_sync_pin <= r[0];
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      repeat (6) @(posedge clk);
      #1;
    end
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches = mismatches + 1;
      wrap_up;
    end
  end

  initial begin
    for (i = 0; i < 4; i = i + 1) begin
      row(i);
      cmp("min_ns", min_ns[i], min_on_time_ns_q);
      cmp("min_cy", min_cy[i], min_on_cycles_q);
      cmp("pfm_ns", pfm_ns[3 - i], pfm_on_time_ns_q);
      cmp("pfm_cy", pfm_cy[3 - i], pfm_on_cycles_q);
      cmp("slope", sl_val[i], slope_mv_per_us_q);
      cmp("soft", i[0], soft_start_sel_q);
      cmp("ilim", i[1:0], current_limit_sel_q);
      cmp("pfm", i == 0 || i == 3, pfm_mode_q);
      cmp("sync", i == 1, sync_clock_q);
      rd_chk(4'h5, sl_val[i]);
      rd_chk(4'h4, {6'h00, 1'b1, i == 0 || i == 3, i[1], i[1:0], i[0], ~i[1:0], i[1:0]});
      rd_chk(4'h0, (i == 0) ? 16'h0000 : 16'h0003);
    end
    row(1);
    wr_reg(4'h4, 16'h0000);
    rd_chk(4'h4, 16'h0239);
    rd_chk(4'hF, 16'h0000);
    wr_reg(4'h0, 16'h0001);
    repeat (4) @(posedge clk);
    #1 cmp("pfm", 0, pfm_mode_q);
    wr_reg(4'h0, 16'h0000);
    repeat (4) @(posedge clk);
    #1 cmp("pfm", 1, pfm_mode_q);
    rd_chk(4'h0, 16'h0000);
    wr_reg(4'h0, 16'h0003);
    @(posedge clk);
    regulator_enable <= 1'b1;
    repeat (4) @(posedge clk);
    #1 cmp("run", 1, regulator_run_q);
    wr_reg(4'h0, 16'h0000);
    wait (pfm_mode_q === 1'b1);
    slow <= 1'b0;
    wr_reg(4'h0, 16'h0003);
    wait (pfm_mode_q === 1'b0);
    wr_reg(4'h3, 16'h0003);
    ov_cmd <= 1'b1;
    repeat (5) @(posedge clk);
    #1 cmp("pg_a", 1, power_good_out_a_q);
    cmp("pg_b", 0, power_good_out_b_q);
    cmp("irq", 1, irq_q);
    rd_chk(4'h1, 16'h000A);
    wr_reg(4'h1, 16'h0002);
    rd_chk(4'h1, 16'h000A);
    @(posedge clk);
    ov_cmd <= 1'b0;
    repeat (5) @(posedge clk);
    #1 cmp("pg_a", 0, power_good_out_a_q);
    rd_chk(4'h1, 16'h0002);
    rd_chk(4'h2, 16'h0002);
    repeat (2) @(posedge clk);
    #1 cmp("irq", 0, irq_q);
    wr_reg(4'h1, 16'h0001);
    rd_chk(4'h1, 16'h0002);
    wr_reg(4'h1, 16'h000E);
    rd_chk(4'h1, 16'h0000);
    wr_reg(4'h3, 16'h0002);
    uv_cmd <= 1'b1;
    repeat (5) @(posedge clk);
    #1 cmp("pg_b", 1, power_good_out_b_q);
    cmp("pg_a", 0, power_good_out_a_q);
    cmp("irq", 0, irq_q);
    rd_chk(4'h1, 16'h0005);
    rd_chk(4'h2, 16'h0001);
    // A write while the clock enable is low must leave the mask alone
    @(posedge clk);
    clk_en <= 1'b0;
    wr_reg(4'h3, 16'h0000);
    @(posedge clk);
    clk_en <= 1'b1;
    rd_chk(4'h3, 16'h0002);
    #1 cmp("pg_b", 1, power_good_out_b_q);
    wrap_up;
  end
endmodule // test_xfbc_ctrl
